/* File: ofd_pkg.sv */
// Purpose: Constants for the output force and disarm test controller.
// Assumes: 100 MHz clk_sys, APB slave with 32-bit data.
// Notes: Summary of operation below.
// Summary of operation
// - Timed output force holds only while its timer runs, then contact is normal.
// - Permanent output force holds until forcing is cancelled.
// - Group force overrides single-contact force within the same group.
// - A disarmed contact ignores force commands.
// - Contact is forced only if not disarmed and force command applied.
// - A disarmed group has switching suppressed on all contacts except zone-interlock, supervision, latched or hold-running ones.
// - Zone-interlock output and supervision contact are never disarmed.
// - Timed group disarm holds only while its timer runs.
// - Permanent group disarm holds until cancelled.
// - A latched, not yet reset contact is not disarmed; a contact that latches after it is disarmed stays disarmed.
// - Disarm waits for a running off-delay hold timer to expire.
// - Disarm needs disarm control active and direct disarm command applied.
// - Temperature force holds permanently or until its timeout expires.
// - Displayed temperatures freeze while temperature forcing is active.
// - Live temperatures are shown again when forcing ends.
// - An operator reboot request performs a full reboot.
// - Healthy indicator steady green only after boot with protection running.
// - Flag set when calculated phase sequence differs from the setting.
package ofd_pkg;
  localparam int NOUT = 8;
  localparam int TW = 16;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FVAL = 8'h04;
  localparam logic [7:0] ADDR_TOUT = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQS = 8'h10;
  localparam logic [7:0] ADDR_IMSK = 8'h14;
  localparam logic [7:0] ADDR_TEMP = 8'h18;
  localparam logic [7:0] ADDR_OUTS = 8'h1c;
  // Control register bit positions.
  localparam int C_FSGL = 0;
  localparam int C_FGRP = 1;
  localparam int C_FPERM = 2;
  localparam int C_DCTL = 3;
  localparam int C_DCMD = 4;
  localparam int C_DPERM = 5;
  localparam int C_TFRC = 6;
  localparam int C_TPERM = 7;
  localparam int C_BOOT = 8;
  localparam int C_FSEL = 16;
  // Fixed indices of never-disarmed outputs.
  localparam int ZONE_IDX = 6;
  localparam int SUPV_IDX = 7;
  // Timeout tick period: 1 ms at 100 MHz.
  localparam int TICK_NS = 1000000;
  localparam int CLK_NS = 10;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  typedef enum logic [1:0] {OFD_BOOT, OFD_RUN, OFD_REBOOT} ofd_state_t;
endpackage

/* File: ofd_output_force_disarm.sv */
// Purpose: Force and disarm control of relay outputs and temperature inputs.
// Assumes: Controls arrive over APB; relay/latch/hold inputs are asynchronous.
// Notes: Timeouts count 1 ms ticks.
`timescale 1ns/1ns
module ofd_output_force_disarm
  import ofd_pkg::*;
#(
  parameter int TICK_CYCLES = ofd_pkg::TICK_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Relay side.
  input wire logic [ofd_pkg::NOUT-1:0] relayLogic,
  input wire logic [ofd_pkg::NOUT-1:0] relayLatched,
  input wire logic [ofd_pkg::NOUT-1:0] relayHoldRun,
  output logic [ofd_pkg::NOUT-1:0] relayDrive,
  output logic [ofd_pkg::NOUT-1:0] relayDisarmed,
  // Temperature side.
  input wire logic [15:0] tempLive,
  output logic [15:0] tempOut,
  output logic [15:0] tempShown,
  // Status and system.
  input wire logic protRunning,
  input wire logic [1:0] phaseCalc,
  input wire logic [1:0] phaseSetting,
  output logic healthyGreen,
  output logic phaseMismatch,
  output logic rebootReq,
  output logic irq
);
  import ofd_pkg::*;

  logic [31:0] ctrl_q;
  logic [31:0] fval_q;
  logic [31:0] tout_q;
  logic [2:0] irqs_q;
  logic [2:0] imsk_q;
  logic [15:0] tempFrozen_q;
  logic [15:0] tempForce_q;
  logic [TW-1:0] fTimer_q;
  logic [TW-1:0] dTimer_q;
  logic [TW-1:0] tTimer_q;
  logic [31:0] tickCnt_q;
  logic tick;
  logic fActive_q;
  logic dActive_q;
  logic tActive_q;
  logic [NOUT-1:0] disarm_q;
  logic [NOUT-1:0] latS1_q, latS2_q, holdS1_q, holdS2_q, relS1_q, relS2_q;
  logic [1:0] phcS1_q, phcS2_q, phsS1_q, phsS2_q;
  logic protS1_q, protS2_q;
  ofd_state_t state_q;
  logic wrEn;
  logic rdEn;
  logic fReq;
  logic dReq;
  logic tReq;
  logic [NOUT-1:0] forceMask;
  logic [NOUT-1:0] disarmable;
  logic [NOUT-1:0] disarm_d;
  logic fExpire;
  logic dExpire;
  logic tExpire;

  // Marks the tick on which a timed request runs out.
  function automatic logic timerExpired(input logic active,
    input logic perm, input logic tk, input logic [TW-1:0] count);
    timerExpired = active && !perm && tk && count == 16'h0001;
  endfunction

  always_ff @(posedge clk_sys) begin
    latS1_q <= relayLatched;
    latS2_q <= latS1_q;
    holdS1_q <= relayHoldRun;
    holdS2_q <= holdS1_q;
    relS1_q <= relayLogic;
    relS2_q <= relS1_q;
    phcS1_q <= phaseCalc;
    phcS2_q <= phcS1_q;
    phsS1_q <= phaseSetting;
    phsS2_q <= phsS1_q;
    protS1_q <= protRunning;
    protS2_q <= protS1_q;
  end

  assign pready = 1'b1;
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign pslverr = psel && penable && (paddr > ADDR_OUTS || paddr[1:0] != 2'b00);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      fval_q <= 32'h0000_0000;
      tout_q <= 32'h0000_0000;
      imsk_q <= 3'h0;
    end else if (wrEn) begin
      case (paddr)
        ADDR_CTRL: ctrl_q <= pwdata;
        ADDR_FVAL: fval_q <= pwdata;
        ADDR_TOUT: tout_q <= pwdata;
        ADDR_IMSK: imsk_q <= pwdata[2:0];
        default: ;
      endcase
    end else begin
      // A timed request that expired clears its own request bit.
      if (fExpire) begin
        ctrl_q[C_FSGL] <= 1'b0;
        ctrl_q[C_FGRP] <= 1'b0;
      end
      if (dExpire) begin
        ctrl_q[C_DCMD] <= 1'b0;
      end
      if (tExpire) begin
        ctrl_q[C_TFRC] <= 1'b0;
      end
      if (ctrl_q[C_BOOT]) begin
        ctrl_q[C_BOOT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || tick) begin
      tickCnt_q <= 32'h0000_0000;
    end else begin
      tickCnt_q <= tickCnt_q + 32'h0000_0001;
    end
  end
  assign tick = (tickCnt_q == 32'(TICK_CYCLES - 1));

  assign fReq = ctrl_q[C_FSGL] || ctrl_q[C_FGRP];
  assign dReq = ctrl_q[C_DCTL] && ctrl_q[C_DCMD];
  assign tReq = ctrl_q[C_TFRC];
  assign fExpire = timerExpired(fActive_q, ctrl_q[C_FPERM], tick,
                                fTimer_q);
  assign dExpire = timerExpired(dActive_q, ctrl_q[C_DPERM], tick,
                                dTimer_q);
  assign tExpire = timerExpired(tActive_q, ctrl_q[C_TPERM], tick,
                                tTimer_q);

  always_ff @(posedge clk_sys) begin
    if (rst || !fReq) begin
      fActive_q <= 1'b0;
      fTimer_q <= '0;
    end else if (!fActive_q) begin
      fActive_q <= 1'b1;
      fTimer_q <= tout_q[TW-1:0];
    end else if (!ctrl_q[C_FPERM] && tick && fTimer_q != '0) begin
      fTimer_q <= fTimer_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !dReq) begin
      dActive_q <= 1'b0;
      dTimer_q <= '0;
    end else if (!dActive_q) begin
      dActive_q <= 1'b1;
      dTimer_q <= tout_q[2*TW-1:TW];
    end else if (!ctrl_q[C_DPERM] && tick && dTimer_q != '0) begin
      dTimer_q <= dTimer_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !tReq) begin
      tActive_q <= 1'b0;
      tTimer_q <= '0;
    end else if (!tActive_q) begin
      tActive_q <= 1'b1;
      tTimer_q <= tout_q[TW-1:0];
    end else if (!ctrl_q[C_TPERM] && tick && tTimer_q != '0) begin
      tTimer_q <= tTimer_q - 16'h0001;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NOUT; gi++) begin : g_out
      if (gi == ZONE_IDX || gi == SUPV_IDX) begin : g_fixed
        assign disarmable[gi] = 1'b0;
      end else begin : g_arm
        assign disarmable[gi] = 1'b1;
      end
      assign forceMask[gi] = ctrl_q[C_FGRP] ||
        (ctrl_q[C_FSGL] && ctrl_q[C_FSEL+2:C_FSEL] == 3'(gi));
      // Next disarm state, shared by the flag and the drive so both agree.
      assign disarm_d[gi] = !dActive_q ? 1'b0 :
        (disarmable[gi] && !latS2_q[gi] && !holdS2_q[gi]) ? 1'b1 :
        disarm_q[gi];
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          disarm_q[gi] <= 1'b0;
        end else begin
          disarm_q[gi] <= disarm_d[gi];
        end
      end
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          relayDrive[gi] <= 1'b0;
        end else if (disarm_d[gi]) begin
          relayDrive[gi] <= 1'b0;
        end else if (fActive_q && forceMask[gi]) begin
          // Group force uses the group value bit, single force its own bit.
          relayDrive[gi] <= ctrl_q[C_FGRP] ? fval_q[8] : fval_q[gi];
        end else begin
          relayDrive[gi] <= relS2_q[gi];
        end
      end
    end
  endgenerate
  assign relayDisarmed = disarm_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tempFrozen_q <= 16'h0000;
      tempForce_q <= 16'h0000;
      tempOut <= 16'h0000;
      tempShown <= 16'h0000;
    end else begin
      tempForce_q <= fval_q[31:16];
      if (!tActive_q) begin
        tempFrozen_q <= tempLive;
        tempShown <= tempLive;
        tempOut <= tempLive;
      end else begin
        tempShown <= tempFrozen_q;
        tempOut <= tempForce_q;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= OFD_BOOT;
    end else begin
      case (state_q)
        OFD_BOOT: if (protS2_q) state_q <= OFD_RUN;
        OFD_RUN: begin
          if (ctrl_q[C_BOOT]) begin
            state_q <= OFD_REBOOT;
          end else if (!protS2_q) begin
            state_q <= OFD_BOOT;
          end
        end
        OFD_REBOOT: state_q <= OFD_BOOT;
        default: state_q <= OFD_BOOT;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      healthyGreen <= 1'b0;
      rebootReq <= 1'b0;
      phaseMismatch <= 1'b0;
    end else begin
      healthyGreen <= (state_q == OFD_RUN) && protS2_q;
      rebootReq <= (state_q == OFD_REBOOT);
      phaseMismatch <= (phcS2_q != phsS2_q);
    end
  end

  // Events: force expiry, disarm expiry, phase mismatch rise.
  logic [2:0] evt;
  assign evt[0] = fExpire;
  assign evt[1] = dExpire;
  assign evt[2] = (phcS2_q != phsS2_q) && !phaseMismatch;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqs_q <= 3'h0;
    end else if (rdEn && paddr == ADDR_IRQS) begin
      irqs_q <= evt;
    end else begin
      irqs_q <= irqs_q | evt;
    end
  end
  assign irq = |(irqs_q & imsk_q);

  always_comb begin
    prdata = 32'h0000_0000;
    if (rdEn) begin
      case (paddr)
        ADDR_CTRL: prdata = ctrl_q;
        ADDR_FVAL: prdata = fval_q;
        ADDR_TOUT: prdata = tout_q;
        ADDR_STAT: prdata = {24'h000000, 2'b00, rebootReq, healthyGreen,
                             phaseMismatch, tActive_q, dActive_q, fActive_q};
        ADDR_IRQS: prdata = {29'h0, irqs_q};
        ADDR_IMSK: prdata = {29'h0, imsk_q};
        ADDR_TEMP: prdata = {tempOut, tempShown};
        ADDR_OUTS: prdata = {16'h0000, disarm_q, relayDrive};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule

/* File: ofd_output_force_disarm_checker.sv */
// Purpose: Port-level assertions for the force and disarm controller.
// Assumes: Synchronous rst, relay and status inputs synced in the design.
// Notes: Bound into every instance of the controller.
`timescale 1ns/1ns
module ofd_output_force_disarm_checker
  import ofd_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Relay side.
  input wire logic [ofd_pkg::NOUT-1:0] relayLatched,
  input wire logic [ofd_pkg::NOUT-1:0] relayHoldRun,
  input wire logic [ofd_pkg::NOUT-1:0] relayDrive,
  input wire logic [ofd_pkg::NOUT-1:0] relayDisarmed,
  // Status and system.
  input wire logic protRunning,
  input wire logic [1:0] phaseCalc,
  input wire logic [1:0] phaseSetting,
  input wire logic healthyGreen,
  input wire logic phaseMismatch,
  input wire logic rebootReq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_boot_wr;
    psel && penable && pwrite && paddr == ADDR_CTRL && pwdata[C_BOOT];
  endsequence
  sequence s_mismatch;
    (phaseCalc != phaseSetting) [*6];
  endsequence
  a_fixed_armed: assert property (!relayDisarmed[ZONE_IDX] &&
    !relayDisarmed[SUPV_IDX]) else $error("fixed output disarmed");
  a_disarmed_quiet: assert property ((relayDrive & relayDisarmed)
    == '0) else $error("disarmed output driven");
  a_phase_set: assert property (s_mismatch |-> phaseMismatch)
    else $error("phase flag missing");
  a_phase_clear: assert property ((phaseCalc == phaseSetting) [*6]
    |-> !phaseMismatch) else $error("phase flag spurious");
  a_bad_addr: assert property (psel && penable && paddr > ADDR_OUTS
    |-> pslverr && prdata == '0) else $error("bad address accepted");
  a_reboot_req: assert property (s_boot_wr |-> ##[1:3] rebootReq)
    else $error("reboot not requested");
  a_reboot_pulse: assert property (rebootReq |=> !rebootReq)
    else $error("reboot request too long");
  a_healthy_run: assert property (!protRunning [*6]
    |-> !healthyGreen) else $error("healthy without protection");
  for (genvar i = 0; i < NOUT; i++) begin : g_bit
    a_disarm_block: assert property ((relayLatched[i] ||
      relayHoldRun[i]) [*4] |-> !$rose(relayDisarmed[i]))
      else $error("blocked output disarmed");
  end
endmodule
bind ofd_output_force_disarm ofd_output_force_disarm_checker
  #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .relayLatched(relayLatched), .relayHoldRun(relayHoldRun),
  .relayDrive(relayDrive), .relayDisarmed(relayDisarmed),
  .protRunning(protRunning), .phaseCalc(phaseCalc),
  .phaseSetting(phaseSetting), .healthyGreen(healthyGreen),
  .phaseMismatch(phaseMismatch), .rebootReq(rebootReq));

/* File: ofd_output_force_disarm_bench.sv */
// Purpose: Self-checking bench for the force and disarm controller.
// Assumes: TICK_CYCLES of 4, so one timeout unit is 4 clocks.
// Notes: Random contact levels and values from a fixed seed.
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  err_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module ofd_output_force_disarm_bench;
  import ofd_pkg::*;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0, relayLogic = '0, relayLatched = '0;
  logic [7:0] relayHoldRun = '0, relayDrive, relayDisarmed, lv, fv;
  logic [31:0] pwdata = '0, prdata, rdv;
  logic pready, pslverr, errv, gv, protRunning = 0;
  logic healthyGreen, phaseMismatch, rebootReq, irq;
  logic [15:0] tempLive = '0, tempOut, tempShown, ta, tb, tf;
  logic [1:0] phaseCalc = '0, phaseSetting = '0;
  int err_count = 0, total_checks = 0, cycles = 0, sel;
  ofd_output_force_disarm #(.TICK_CYCLES(4)) u_dut (.clk_sys(clk_sys),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .relayLogic(relayLogic),
    .relayLatched(relayLatched), .relayHoldRun(relayHoldRun),
    .relayDrive(relayDrive), .relayDisarmed(relayDisarmed),
    .tempLive(tempLive), .tempOut(tempOut), .tempShown(tempShown),
    .protRunning(protRunning), .phaseCalc(phaseCalc),
    .phaseSetting(phaseSetting), .healthyGreen(healthyGreen),
    .phaseMismatch(phaseMismatch), .rebootReq(rebootReq), .irq(irq));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic stop_test();
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 3000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic [7:0] put(logic [7:0] l, int s, logic v);
    put = l;
    put[s] = v;
  endfunction
  initial begin
    void'($urandom(44891));
    cyc(8);
    rst <= 0;
    apb(1, ADDR_IMSK, 32'h0000_0003);
    apb(0, ADDR_CTRL, '0);
    `CHK("ctrl", CTRL_RST, rdv)
    apb(0, 8'h20, '0);
    `CHK("bad err", 1'b1, errv)
    `CHK("bad data", 32'h0, rdv)
    lv = $urandom;
    fv = $urandom;
    sel = $urandom_range(NOUT - 1);
    relayLogic <= lv;
    apb(1, ADDR_TOUT, 32'h0000_0005);
    apb(1, ADDR_FVAL, {24'h0, fv});
    apb(1, ADDR_CTRL, 32'h1 | (32'(sel) << C_FSEL));
    cyc(5);
    `CHK("forced", put(lv, sel, fv[sel]), relayDrive)
    cyc(30);
    `CHK("expired", lv, relayDrive)
    `CHK("irq set", 1'b1, irq)
    apb(0, ADDR_IRQS, '0);
    `CHK("irq src", 1'b1, rdv[0])
    cyc(1);
    `CHK("irq clr", 1'b0, irq)
    gv = $urandom;
    apb(1, ADDR_FVAL, {23'h0, gv, ~{8{gv}}});
    apb(1, ADDR_CTRL, 32'h7 | (32'(sel) << C_FSEL));
    cyc(40);
    `CHK("group", {NOUT{gv}}, relayDrive)
    relayLatched <= 8'h01;
    relayHoldRun <= 8'h02;
    apb(1, ADDR_FVAL, 32'h100);
    apb(1, ADDR_CTRL, 32'h3e);
    cyc(6);
    `CHK("disarm", 8'h3c, relayDisarmed)
    `CHK("drive", 8'hc3, relayDrive)
    relayHoldRun <= 8'h00;
    cyc(6);
    `CHK("hold over", 8'h3e, relayDisarmed)
    apb(1, ADDR_CTRL, 32'h36);
    cyc(6);
    `CHK("no ctrl", 8'h00, relayDisarmed)
    relayLatched <= 8'h00;
    apb(1, ADDR_TOUT, 32'h0005_0005);
    apb(1, ADDR_CTRL, 32'h18);
    cyc(6);
    `CHK("timed dis", 8'h3f, relayDisarmed)
    `CHK("timed drv", lv & 8'hc0, relayDrive)
    cyc(30);
    `CHK("dis end", 8'h00, relayDisarmed)
    apb(0, ADDR_IRQS, '0);
    `CHK("dis irq", 1'b1, rdv[1])
    ta = $urandom;
    tb = $urandom;
    tf = $urandom;
    tempLive <= ta;
    apb(1, ADDR_FVAL, {tf, 16'h0});
    apb(1, ADDR_CTRL, 32'hc0);
    cyc(2);
    tempLive <= tb;
    cyc(40);
    `CHK("t out", tf, tempOut)
    `CHK("t frozen", ta, tempShown)
    apb(0, ADDR_TEMP, '0);
    `CHK("t reg", {tf, ta}, rdv)
    apb(1, ADDR_CTRL, '0);
    cyc(4);
    `CHK("t live", tb, tempShown)
    `CHK("t normal", tb, tempOut)
    apb(1, ADDR_CTRL, 32'h40);
    cyc(6);
    `CHK("t timed", tf, tempOut)
    `CHK("t hold", tb, tempShown)
    cyc(30);
    `CHK("t expired", tb, tempOut)
    apb(1, ADDR_IMSK, '0);
    phaseCalc <= 2'h1;
    cyc(10);
    `CHK("phase", 1'b1, phaseMismatch)
    `CHK("masked", 1'b0, irq)
    apb(0, ADDR_IRQS, '0);
    `CHK("ph irq", 1'b1, rdv[2])
    protRunning <= 1;
    cyc(10);
    `CHK("healthy", 1'b1, healthyGreen)
    apb(1, ADDR_CTRL, 32'h1 << C_BOOT);
    cyc(3);
    `CHK("reboot", 1'b1, rebootReq)
    `CHK("in boot", 1'b0, healthyGreen)
    cyc(10);
    `CHK("rebooted", 1'b1, healthyGreen)
    stop_test();
  end
endmodule
